// file: rtl/cide_defs.svh
// Operation
// - Top bits 101 load a sign-extended 21-bit constant into the destination
// - Opcode 001011 loads one byte at source one, sign-extended
// - Opcode 001010 loads one byte at source one, upper 24 bits zero
// - Opcode 001000 loads the 32-bit word at source one
// - Opcode 010111 gives signed remainder with truncating quotient; zero divisor undefined
// - Opcode 010110 gives unsigned remainder; zero divisor undefined
// - Without divider option both modulo opcodes write zero
// - Opcode 010010 writes low 32 bits of the product
// - No-operation changes no register or memory
// - Opcode 011001 writes bitwise OR of both operands
// - Opcode 011010 writes bitwise XOR of both operands
// - Opcode 010001 writes first minus second operand modulo 2^32
// - Opcode 001110 stores lowest byte of operand two at source one address
// - Opcode 001100 stores the full operand two word at source one address
// - Load and store addresses always come from a register
// - Opcode 011100 shifts left logically; amounts above 31 undefined
// - Opcode 011111 shifts right replicating the sign bit
// - Opcode 011110 shifts right filling zeros
// - One cycle for simple ops, two for shifts, 36 divide, 37 modulo
// - Loads take at least three cycles, stores two, stretched by bus
// - Multiply takes 2, 6 or 34 cycles per build choice
// - Compare-branch 5 taken, 2 not taken; jump and call 4
`ifndef CIDE_DEFS_SVH
`define CIDE_DEFS_SVH

`define CIDE_NUM_REGS 256
`define CIDE_REG_RETURN 8'hFE

`define CIDE_OP_NOP 6'h00
`define CIDE_OP_LOAD_FULL_WORD 6'h08
`define CIDE_OP_LOAD_BYTE_ZERO 6'h0A
`define CIDE_OP_LOAD_BYTE_SIGN 6'h0B
`define CIDE_OP_STORE_FULL_WORD 6'h0C
`define CIDE_OP_STORE_SINGLE_BYTE 6'h0E
`define CIDE_OP_ADD 6'h10
`define CIDE_OP_SUB 6'h11
`define CIDE_OP_MUL 6'h12
`define CIDE_OP_DIV_U 6'h14
`define CIDE_OP_DIV_S 6'h15
`define CIDE_OP_MOD_U 6'h16
`define CIDE_OP_MOD_S 6'h17
`define CIDE_OP_AND 6'h18
`define CIDE_OP_OR 6'h19
`define CIDE_OP_XOR 6'h1A
`define CIDE_OP_SHIFT_LEFT_LOGICAL 6'h1C
`define CIDE_OP_SHIFT_RIGHT_ZERO 6'h1E
`define CIDE_OP_SHIFT_RIGHT_SIGN 6'h1F
`define CIDE_OP_JUMP 6'h20
`define CIDE_OP_CALL 6'h21

`define CIDE_CONST_BITS 5:3
`define CIDE_CONST_TAG 3'h5
`define CIDE_BRANCH_BITS 5:4
`define CIDE_BRANCH_TAG 2'h3
`define CIDE_CND_EQ 3
`define CIDE_CND_NE 2
`define CIDE_CND_UG 1
`define CIDE_CND_SG 0

`define CIDE_SHAMT_BITS 4:0
`define CIDE_LANE_BITS 1:0
`define CIDE_BYTE_BITS 7:0

`define CIDE_LAT_ONE 6'h01
`define CIDE_LAT_SHIFT 6'h02
`define CIDE_LAT_DIV 6'h24
`define CIDE_LAT_MOD 6'h25
`define CIDE_LAT_JUMP 6'h04
`define CIDE_LAT_BR_TAKEN 6'h05
`define CIDE_LAT_BR_NOT 6'h02

`endif

// file: rtl/cide_pkg.sv
package cide_pkg;

	typedef enum logic [3:0]
	{
		CIDE_ST_IDLE = 4'h1,
		CIDE_ST_WAIT = 4'h2,
		CIDE_ST_MEM = 4'h4,
		CIDE_ST_WB = 4'h8
	} cide_state_e;

	typedef struct packed
	{
		logic [5:0] opcode;
		logic first_operand_type;
		logic second_operand_type;
		logic [7:0] dst;
		logic [7:0] first_source_field;
		logic [7:0] second_source_field;
	} cide_insn_s;

	typedef struct packed
	{
		logic cyc;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} cide_dbus_req_s;

endpackage : cide_pkg

// file: rtl/cide_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "cide_defs.svh"

module cide_exec
#(
	parameter bit HAS_DIV = 1'h1,
	parameter int MUL_CYCLES = 2
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic insn_valid,
	input wire logic [31:0] insn_word,
	input wire logic [31:0] insn_next_pc,
	output logic insn_ready,
	output logic jump_valid,
	output logic [31:0] jump_target,
	output var cide_pkg::cide_dbus_req_s dbus_o,
	input wire logic dbus_ack,
	input wire logic [31:0] dbus_rdata
);

	// ************************************************************
	// Reset release
	// ************************************************************
	logic rst_meta_q;
	logic rst_q;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_q <= 1'h0;
			rst_q <= 1'h0;
		end
		else
		begin
			rst_meta_q <= 1'h1;
			rst_q <= rst_meta_q;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_q);

	// ************************************************************
	// Decode
	// ************************************************************
	cide_pkg::cide_insn_s ins;
	cide_pkg::cide_state_e state_q, state_d;
	logic [31:0] reg_q [`CIDE_NUM_REGS];
	logic [31:0] src1_reg, src2_reg, dst_reg, op_a, op_b, alu_res;
	logic [20:0] lcs_val;
	logic [5:0] lat;
	logic alu_wr, accept, taken, is_lcs, is_branch, is_load, is_store, is_byte, is_shift, is_mod, is_jump, is_call;
	logic [5:0] cnt_q, cnt_d, opc_q, opc_d;
	logic [31:0] res_q, res_d, tgt_q, tgt_d, jt_q, jt_d, ld_val;
	logic [7:0] dst_q, dst_d, ld_byte;
	logic [1:0] lane_q, lane_d;
	logic wrp_q, wrp_d, jmpp_q, jmpp_d, jv_q, jv_d;
	cide_pkg::cide_dbus_req_s dbus_q, dbus_d;
	logic wr_en;
	logic [7:0] wr_idx;
	logic [31:0] wr_data;

	assign ins = insn_word;
	assign insn_ready = (state_q == cide_pkg::CIDE_ST_IDLE);
	assign accept = insn_valid && insn_ready;
	assign src1_reg = reg_q[ins.first_source_field];
	assign src2_reg = reg_q[ins.second_source_field];
	assign dst_reg = reg_q[ins.dst];
	// Immediates are sign-extended so small negative constants need no extra word
	assign op_a = ins.first_operand_type ? src1_reg : 32'($signed(ins.first_source_field));
	assign op_b = ins.second_operand_type ? src2_reg : 32'($signed(ins.second_source_field));
	assign lcs_val = {ins.opcode[2:0], ins.first_operand_type, ins.second_operand_type,
		ins.first_source_field, ins.second_source_field};
	assign is_lcs = (ins.opcode[`CIDE_CONST_BITS] == `CIDE_CONST_TAG);
	assign is_branch = (ins.opcode[`CIDE_BRANCH_BITS] == `CIDE_BRANCH_TAG);
	assign is_load = (ins.opcode == `CIDE_OP_LOAD_FULL_WORD) || (ins.opcode == `CIDE_OP_LOAD_BYTE_ZERO)
		|| (ins.opcode == `CIDE_OP_LOAD_BYTE_SIGN);
	assign is_store = (ins.opcode == `CIDE_OP_STORE_FULL_WORD) || (ins.opcode == `CIDE_OP_STORE_SINGLE_BYTE);
	assign is_byte = (ins.opcode == `CIDE_OP_LOAD_BYTE_ZERO) || (ins.opcode == `CIDE_OP_LOAD_BYTE_SIGN)
		|| (ins.opcode == `CIDE_OP_STORE_SINGLE_BYTE);
	assign is_shift = (ins.opcode == `CIDE_OP_SHIFT_LEFT_LOGICAL) || (ins.opcode == `CIDE_OP_SHIFT_RIGHT_ZERO)
		|| (ins.opcode == `CIDE_OP_SHIFT_RIGHT_SIGN);
	assign is_mod = (ins.opcode == `CIDE_OP_MOD_U) || (ins.opcode == `CIDE_OP_MOD_S);
	assign is_call = (ins.opcode == `CIDE_OP_CALL);
	assign is_jump = (ins.opcode == `CIDE_OP_JUMP) || is_call;
	assign taken = (ins.opcode[`CIDE_CND_EQ] && (op_a == op_b)) || (ins.opcode[`CIDE_CND_NE] && (op_a != op_b))
		|| (ins.opcode[`CIDE_CND_UG] && (op_a > op_b)) || (ins.opcode[`CIDE_CND_SG] && ($signed(op_a) > $signed(op_b)));

	// ************************************************************
	// Arithmetic and logic
	// ************************************************************
	// Zero divisor yields zero: undefined by the ISA, but keeps simulation free of X
	always_comb
	begin
		alu_res = '0;
		alu_wr = 1'h1;
		case (ins.opcode)
			`CIDE_OP_ADD: alu_res = op_a + op_b;
			`CIDE_OP_SUB: alu_res = op_a - op_b;
			`CIDE_OP_MUL: alu_res = op_a * op_b;
			`CIDE_OP_AND: alu_res = op_a & op_b;
			`CIDE_OP_OR: alu_res = op_a | op_b;
			`CIDE_OP_XOR: alu_res = op_a ^ op_b;
			`CIDE_OP_SHIFT_LEFT_LOGICAL: alu_res = op_a << op_b[`CIDE_SHAMT_BITS];
			`CIDE_OP_SHIFT_RIGHT_ZERO: alu_res = op_a >> op_b[`CIDE_SHAMT_BITS];
			`CIDE_OP_SHIFT_RIGHT_SIGN: alu_res = 32'($signed(op_a) >>> op_b[`CIDE_SHAMT_BITS]);
			`CIDE_OP_DIV_U: alu_res = (HAS_DIV && (op_b != '0)) ? op_a / op_b : '0;
			`CIDE_OP_DIV_S: alu_res = (HAS_DIV && (op_b != '0)) ? 32'($signed(op_a) / $signed(op_b)) : '0;
			`CIDE_OP_MOD_U: alu_res = (HAS_DIV && (op_b != '0)) ? op_a % op_b : '0;
			`CIDE_OP_MOD_S: alu_res = (HAS_DIV && (op_b != '0)) ? 32'($signed(op_a) % $signed(op_b)) : '0;
			default: alu_wr = 1'h0;
		endcase
		if (is_lcs)
		begin
			alu_res = 32'($signed(lcs_val));
			alu_wr = 1'h1;
		end
	end

	// ************************************************************
	// Latency
	// ************************************************************
	always_comb
	begin
		lat = `CIDE_LAT_ONE;
		case (ins.opcode)
			`CIDE_OP_SHIFT_LEFT_LOGICAL, `CIDE_OP_SHIFT_RIGHT_ZERO, `CIDE_OP_SHIFT_RIGHT_SIGN: lat = `CIDE_LAT_SHIFT;
			`CIDE_OP_MUL: lat = 6'(MUL_CYCLES);
			`CIDE_OP_DIV_U, `CIDE_OP_DIV_S: lat = `CIDE_LAT_DIV;
			`CIDE_OP_MOD_U, `CIDE_OP_MOD_S: lat = `CIDE_LAT_MOD;
			`CIDE_OP_JUMP, `CIDE_OP_CALL: lat = `CIDE_LAT_JUMP;
			default: lat = `CIDE_LAT_ONE;
		endcase
		if (is_branch)
		begin
			lat = taken ? `CIDE_LAT_BR_TAKEN : `CIDE_LAT_BR_NOT;
		end
	end

	// ************************************************************
	// Sequencing
	// ************************************************************
	assign ld_byte = 8'(dbus_rdata >> {lane_q, 3'h0});
	assign ld_val = (opc_q == `CIDE_OP_LOAD_BYTE_SIGN) ? 32'($signed(ld_byte))
		: (opc_q == `CIDE_OP_LOAD_BYTE_ZERO) ? 32'(ld_byte) : dbus_rdata;

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		res_d = res_q;
		dst_d = dst_q;
		wrp_d = wrp_q;
		jmpp_d = jmpp_q;
		tgt_d = tgt_q;
		opc_d = opc_q;
		lane_d = lane_q;
		dbus_d = dbus_q;
		jv_d = 1'h0;
		jt_d = jt_q;
		case (state_q)
			cide_pkg::CIDE_ST_IDLE:
			begin
				if (accept && (is_load || is_store))
				begin
					// Address is always the register value, whatever the type bit says
					opc_d = ins.opcode;
					dst_d = ins.dst;
					lane_d = src1_reg[`CIDE_LANE_BITS];
					dbus_d.cyc = 1'h1;
					dbus_d.we = is_store;
					dbus_d.adr = src1_reg;
					dbus_d.sel = is_byte ? (4'h1 << src1_reg[`CIDE_LANE_BITS]) : 4'hF;
					dbus_d.dat = is_byte ? {4{op_b[`CIDE_BYTE_BITS]}} : op_b;
					state_d = cide_pkg::CIDE_ST_MEM;
				end
				else if (accept && (lat != `CIDE_LAT_ONE))
				begin
					cnt_d = lat - `CIDE_LAT_ONE;
					res_d = is_call ? insn_next_pc : alu_res;
					dst_d = is_call ? `CIDE_REG_RETURN : ins.dst;
					wrp_d = alu_wr || is_call;
					jmpp_d = is_jump || (is_branch && taken);
					tgt_d = is_branch ? dst_reg : src1_reg;
					state_d = cide_pkg::CIDE_ST_WAIT;
				end
			end
			cide_pkg::CIDE_ST_WAIT:
			begin
				cnt_d = cnt_q - `CIDE_LAT_ONE;
				if (cnt_q == `CIDE_LAT_ONE)
				begin
					jv_d = jmpp_q;
					jt_d = tgt_q;
					state_d = cide_pkg::CIDE_ST_IDLE;
				end
			end
			cide_pkg::CIDE_ST_MEM:
			begin
				// Bus latency stretches the instruction here
				if (dbus_ack)
				begin
					dbus_d.cyc = 1'h0;
					dbus_d.we = 1'h0;
					res_d = ld_val;
					state_d = dbus_q.we ? cide_pkg::CIDE_ST_IDLE : cide_pkg::CIDE_ST_WB;
				end
			end
			cide_pkg::CIDE_ST_WB: state_d = cide_pkg::CIDE_ST_IDLE;
			default: state_d = cide_pkg::CIDE_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_q)
	begin
		if (!rst_q)
		begin
			state_q <= cide_pkg::CIDE_ST_IDLE;
			cnt_q <= '0;
			res_q <= '0;
			dst_q <= '0;
			wrp_q <= 1'h0;
			jmpp_q <= 1'h0;
			tgt_q <= '0;
			opc_q <= '0;
			lane_q <= '0;
			dbus_q <= '0;
			jv_q <= 1'h0;
			jt_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			res_q <= res_d;
			dst_q <= dst_d;
			wrp_q <= wrp_d;
			jmpp_q <= jmpp_d;
			tgt_q <= tgt_d;
			opc_q <= opc_d;
			lane_q <= lane_d;
			dbus_q <= dbus_d;
			jv_q <= jv_d;
			jt_q <= jt_d;
		end
	end

	assign dbus_o = dbus_q;
	assign jump_valid = jv_q;
	assign jump_target = jt_q;

	// ************************************************************
	// Register file
	// ************************************************************
	// A no-operation, store or untaken branch never reaches the write port
	assign wr_en = (accept && alu_wr && !is_load && !is_store && (lat == `CIDE_LAT_ONE))
		|| ((state_q == cide_pkg::CIDE_ST_WAIT) && (cnt_q == `CIDE_LAT_ONE) && wrp_q)
		|| (state_q == cide_pkg::CIDE_ST_WB);
	assign wr_idx = insn_ready ? ins.dst : dst_q;
	assign wr_data = insn_ready ? alu_res : res_q;

	for (genvar g = 0; g < `CIDE_NUM_REGS; g++)
	begin : g_reg
		always_ff @(posedge clk_sys or negedge rst_q)
		begin
			if (!rst_q)
			begin
				reg_q[g] <= '0;
			end
			else if (wr_en && (wr_idx == 8'(g)))
			begin
				reg_q[g] <= wr_data;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	logic mem_done;

	assign mem_done = (state_q == cide_pkg::CIDE_ST_MEM) && dbus_ack;

	sequence busy_two_s;
		!insn_ready [*2];
	endsequence

	short_const_a: assert property (accept && is_lcs |-> wr_en && (wr_data == 32'($signed(lcs_val))))
		else $error("short constant not sign-extended");
	byte_sign_a: assert property (mem_done && (opc_q == `CIDE_OP_LOAD_BYTE_SIGN)
		|=> wr_en && (wr_data == 32'($signed($past(ld_byte)))))
		else $error("signed byte load wrong");
	byte_zero_a: assert property (mem_done && (opc_q == `CIDE_OP_LOAD_BYTE_ZERO)
		|=> wr_en && (wr_data == 32'($past(ld_byte))))
		else $error("unsigned byte load wrong");
	load_word_a: assert property (mem_done && (opc_q == `CIDE_OP_LOAD_FULL_WORD)
		|=> wr_en && (wr_data == $past(dbus_rdata)))
		else $error("word load wrong");
	mod_identity_a: assert property (accept && (ins.opcode == `CIDE_OP_MOD_S) && HAS_DIV && (op_b != '0)
		|=> ($past(op_a) == 32'($signed($past(op_b)) * ($signed($past(op_a)) / $signed($past(op_b))) + $signed(res_q))))
		else $error("signed remainder identity broken");
	mul_low_a: assert property (accept && (ins.opcode == `CIDE_OP_MUL)
		|=> (res_q == ($past(op_a) * $past(op_b))))
		else $error("product low word wrong");
	or_result_a: assert property (accept && (ins.opcode == `CIDE_OP_OR)
		|-> wr_en && (wr_data == (op_a | op_b)))
		else $error("or result wrong");
	xor_result_a: assert property (accept && (ins.opcode == `CIDE_OP_XOR)
		|-> wr_en && (wr_data == (op_a ^ op_b)))
		else $error("xor result wrong");
	shift_left_a: assert property (accept && (ins.opcode == `CIDE_OP_SHIFT_LEFT_LOGICAL)
		|=> (res_q == ($past(op_a) << $past(op_b[`CIDE_SHAMT_BITS]))))
		else $error("left shift wrong");
	shift_sign_a: assert property (accept && (ins.opcode == `CIDE_OP_SHIFT_RIGHT_SIGN)
		|=> (res_q == 32'($signed($past(op_a)) >>> $past(op_b[`CIDE_SHAMT_BITS]))))
		else $error("signed right shift wrong");
	shift_zero_a: assert property (accept && (ins.opcode == `CIDE_OP_SHIFT_RIGHT_ZERO)
		|=> (res_q == ($past(op_a) >> $past(op_b[`CIDE_SHAMT_BITS]))))
		else $error("unsigned right shift wrong");
	word_store_a: assert property (dbus_o.cyc && dbus_o.we && (opc_q == `CIDE_OP_STORE_FULL_WORD)
		|-> (dbus_o.sel == 4'hF))
		else $error("word store lanes wrong");
	byte_data_a: assert property (dbus_o.cyc && dbus_o.we && (opc_q == `CIDE_OP_STORE_SINGLE_BYTE)
		|-> (dbus_o.dat == {4{dbus_o.dat[`CIDE_BYTE_BITS]}}))
		else $error("byte store data wrong");
	jump_pulse_a: assert property (jump_valid |=> !jump_valid)
		else $error("jump pulse longer than one cycle");
	sub_result_a: assert property (accept && (ins.opcode == `CIDE_OP_SUB) |-> wr_en && (wr_data == op_a - op_b) ##1 insn_ready)
		else $error("subtract wrong or slow");
	nop_quiet_a: assert property (accept && (ins.opcode == `CIDE_OP_NOP) |-> !wr_en ##1 (insn_ready && !dbus_o.cyc))
		else $error("no-operation changed state");
	store_lane_a: assert property (dbus_o.cyc && dbus_o.we && (opc_q == `CIDE_OP_STORE_SINGLE_BYTE)
		|-> (dbus_o.sel == (4'h1 << lane_q)) && (dbus_o.adr[`CIDE_LANE_BITS] == lane_q))
		else $error("byte store lane wrong");
	shift_time_a: assert property (accept && is_shift |=> !insn_ready ##1 insn_ready)
		else $error("shift not two cycles");
	mod_time_a: assert property (accept && is_mod |=> (!insn_ready) [*8] ##28 !insn_ready ##1 insn_ready)
		else $error("modulo not 37 cycles");
	load_time_a: assert property (accept && is_load |=> busy_two_s)
		else $error("load shorter than three cycles");
	store_time_a: assert property (accept && is_store |=> !insn_ready)
		else $error("store shorter than two cycles");
	branch_taken_a: assert property (accept && is_branch && taken |=> (!jump_valid) [*4] ##1 jump_valid)
		else $error("taken branch not five cycles");
	branch_not_a: assert property (accept && is_branch && !taken |=> !jump_valid ##1 (insn_ready && !jump_valid))
		else $error("untaken branch not two cycles");

endmodule : cide_exec

`default_nettype wire

// file: dv/cide_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Data bus memory slave
// ********************************
module cide_mem_model
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire cide_pkg::cide_dbus_req_s dbus_o,
	input wire logic [3:0] ack_delay,
	output logic dbus_ack,
	output logic [31:0] dbus_rdata,
	output logic [15:0] n_access
);
	logic [31:0] mem [0:31];
	logic [3:0] wait_q;
	logic [4:0] idx;
	assign idx = dbus_o.adr[6:2];
	// Ack in the first cyc cycle when no delay is asked, so the shortest access can be measured
	assign dbus_ack = dbus_o.cyc && (wait_q == ack_delay);
	// Read lines show the inverse outside the ack cycle so stale data never passes for a good read
	assign dbus_rdata = dbus_ack ? mem[idx] : ~mem[idx];
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_q <= 4'h0;
			n_access <= 16'h0;
		end
		else if (dbus_ack)
		begin
			wait_q <= 4'h0;
			n_access <= n_access + 16'h1;
			for (int i = 0; i < 4; i++)
			begin
				if (dbus_o.we && dbus_o.sel[i])
				begin
					mem[idx][8*i+:8] <= dbus_o.dat[8*i+:8];
				end
			end
		end
		else
		begin
			wait_q <= wait_q + {3'h0, dbus_o.cyc};
		end
	end
endmodule : cide_mem_model
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cide_defs.svh"
module tb;
	localparam int MUL = 6;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic insn_valid = 1'b0;
	logic [31:0] insn_word = 32'h0;
	logic [31:0] insn_next_pc = 32'h00000100;
	logic [3:0] ack_delay = 4'h0;
	logic insn_ready;
	logic jump_valid;
	logic dbus_ack;
	logic [31:0] jump_target;
	logic [31:0] dbus_rdata;
	logic [31:0] jt;
	logic [15:0] n_access;
	cide_pkg::cide_dbus_req_s dbus_o;
	int mismatches = 0;
	int n_tests = 0;

	always #25 clk_sys = ~clk_sys;

	cide_exec #(.HAS_DIV(1'h1), .MUL_CYCLES(MUL)) i_cide_exec
	(
		.clk_sys(clk_sys), .rstn(rstn), .insn_valid(insn_valid), .insn_word(insn_word),
		.insn_next_pc(insn_next_pc), .insn_ready(insn_ready), .jump_valid(jump_valid),
		.jump_target(jump_target), .dbus_o(dbus_o), .dbus_ack(dbus_ack), .dbus_rdata(dbus_rdata)
	);

	cide_mem_model u_mem
	(
		.clk_sys(clk_sys), .rstn(rstn), .dbus_o(dbus_o), .ack_delay(ack_delay),
		.dbus_ack(dbus_ack), .dbus_rdata(dbus_rdata), .n_access(n_access)
	);

	// ********************************
	// Helpers
	// ********************************
	task automatic end_of_test();
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	function automatic logic [31:0] op(input logic [5:0] c, input logic t2, input logic [7:0] d,
		input logic [7:0] s1, input logic [7:0] s2);
		return {c, 1'b1, t2, d, s1, s2};
	endfunction : op

	function automatic logic [31:0] alu(input logic [5:0] c, input logic [31:0] a, input logic [31:0] b);
		case (c)
			`CIDE_OP_SUB: return a - b;
			`CIDE_OP_OR: return a | b;
			`CIDE_OP_XOR: return a ^ b;
			`CIDE_OP_MUL: return a * b;
			`CIDE_OP_SHIFT_LEFT_LOGICAL: return a << b[4:0];
			`CIDE_OP_SHIFT_RIGHT_SIGN: return $signed(a) >>> b[4:0];
			`CIDE_OP_SHIFT_RIGHT_ZERO: return a >> b[4:0];
			`CIDE_OP_MOD_S: return $signed(a) % $signed(b);
			default: return a % b;
		endcase
	endfunction : alu

	function automatic int lat(input logic [5:0] c);
		case (c)
			`CIDE_OP_SUB, `CIDE_OP_OR, `CIDE_OP_XOR: return 1;
			`CIDE_OP_MUL: return MUL;
			`CIDE_OP_MOD_S, `CIDE_OP_MOD_U: return 37;
			default: return 2;
		endcase
	endfunction : lat

	// Leaves a spare cycle after each instruction, so valid is never driven twice in one step
	task automatic run(input logic [31:0] w, input int cycles);
		int n;
		insn_valid = 1'b1;
		insn_word = w;
		n = 0;
		while (insn_ready !== 1'b1 && n < 200)
		begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		insn_valid = 1'b0;
		n = 1;
		jt = 32'h0;
		while (n < 200)
		begin
			if (jump_valid === 1'b1)
				jt = jump_target;
			if (insn_ready === 1'b1)
				break;
			@(negedge clk_sys);
			n++;
		end
		check(32'(n), 32'(cycles));
		@(negedge clk_sys);
	endtask : run

	task automatic put(input logic [7:0] d, input logic [20:0] v);
		run({3'h5, v[20:16], d, v[15:0]}, 1);
	endtask : put

	task automatic stored(input logic [7:0] r, input logic [31:0] exp);
		run(op(`CIDE_OP_STORE_FULL_WORD, 1'b1, 8'h00, 8'h01, r), 2 + int'(ack_delay));
		check(u_mem.mem[16], exp);
	endtask : stored

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_lcs();
		put(8'h01, 21'h000040);
		put(8'h07, 21'h100000);
		stored(8'h07, 32'hFFF00000);
		put(8'h07, 21'h0FFFFF);
		stored(8'h07, 32'h000FFFFF);
	endtask : t_lcs

	task automatic t_alu();
		logic [5:0] ops [10];
		logic [5:0] c;
		logic [31:0] b;
		ops = '{`CIDE_OP_SUB, `CIDE_OP_OR, `CIDE_OP_XOR, `CIDE_OP_MUL, `CIDE_OP_SHIFT_LEFT_LOGICAL,
			`CIDE_OP_SHIFT_RIGHT_SIGN, `CIDE_OP_SHIFT_RIGHT_ZERO, `CIDE_OP_MOD_S, `CIDE_OP_MOD_U, `CIDE_OP_OR};
		put(8'h02, 21'h1FFC18);
		put(8'h03, 21'h00000D);
		for (int i = 0; i < 10; i++)
		begin
			c = ops[i];
			b = (i == 9) ? 32'hFFFFFFF0 : 32'h0000000D;
			run(op(c, i != 9, 8'h04, 8'h02, (i == 9) ? 8'hF0 : 8'h03), lat(c));
			stored(8'h04, alu(c, 32'hFFFFFC18, b));
		end
	endtask : t_alu

	task automatic t_load();
		logic [31:0] w;
		w = 32'h80C17F25;
		u_mem.mem[3] = w;
		for (int l = 0; l < 4; l++)
		begin
			put(8'h05, 21'(12 + l));
			run(op(`CIDE_OP_LOAD_BYTE_SIGN, 1'b0, 8'h06, 8'h05, 8'h00), 3);
			stored(8'h06, {{24{w[8*l+7]}}, w[8*l+:8]});
			run(op(`CIDE_OP_LOAD_BYTE_ZERO, 1'b0, 8'h06, 8'h05, 8'h00), 3);
			stored(8'h06, {24'h0, w[8*l+:8]});
		end
		ack_delay = 4'h2;
		put(8'h05, 21'h00000C);
		run(op(`CIDE_OP_LOAD_FULL_WORD, 1'b0, 8'h06, 8'h05, 8'h00), 5);
		stored(8'h06, w);
		ack_delay = 4'h0;
	endtask : t_load

	task automatic t_sbyte();
		logic [31:0] e;
		e = 32'h11223344;
		u_mem.mem[5] = e;
		put(8'h07, 21'h10BDC0);
		for (int l = 0; l < 4; l++)
		begin
			put(8'h05, 21'(20 + l));
			run(op(`CIDE_OP_STORE_SINGLE_BYTE, 1'b1, 8'h00, 8'h05, 8'h07), 2);
			e[8*l+:8] = 8'hC0;
			check(u_mem.mem[5], e);
		end
	endtask : t_sbyte

	task automatic t_misc();
		logic [15:0] n0;
		put(8'h04, 21'h000ABC);
		n0 = n_access;
		run(32'h00000000, 1);
		check({16'h0, n_access}, {16'h0, n0});
		stored(8'h04, 32'h00000ABC);
		run(op(`CIDE_OP_JUMP, 1'b0, 8'h00, 8'h01, 8'h00), 4);
		check(jt, 32'h00000040);
		run(op(6'h38, 1'b1, 8'h01, 8'h04, 8'h04), 5);
		check(jt, 32'h00000040);
		run(op(6'h34, 1'b1, 8'h01, 8'h04, 8'h04), 2);
		check(jt, 32'h00000000);
		run(op(`CIDE_OP_CALL, 1'b0, `CIDE_REG_RETURN, 8'h01, 8'h00), 4);
		check(jt, 32'h00000040);
		stored(`CIDE_REG_RETURN, 32'h00000100);
	endtask : t_misc

	initial
	begin
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (4) @(negedge clk_sys);
		t_lcs();
		t_alu();
		t_load();
		t_sbyte();
		t_misc();
		end_of_test();
	end

	initial
	begin
		repeat (10000) @(posedge clk_sys);
		mismatches++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
